// File: common/serial_pkg.sv
// constants, register map and types of the asynchronous serial unit
package serial_pkg;
   // register byte offsets
   localparam logic [7:0] MODE_OFS = 8'h00;
   localparam logic [7:0] ERRSTAT_OFS = 8'h04;
   localparam logic [7:0] TXSTAT_OFS = 8'h08;
   localparam logic [7:0] TXBUF_OFS = 8'h0c;
   localparam logic [7:0] RXBUF_OFS = 8'h10;
   localparam logic [7:0] BASEDIV_OFS = 8'h14;
   localparam logic [7:0] BITLEN_OFS = 8'h18;
   localparam logic [7:0] IRQSTAT_OFS = 8'h1c;
   localparam logic [7:0] IRQMASK_OFS = 8'h20;
   // reset values
   localparam logic [6:0] MODE_RST = 7'h00;
   localparam logic [7:0] BASEDIV_RST = 8'h00;
   localparam logic [7:0] BITLEN_RST = 8'h10;
   localparam logic [2:0] IRQMASK_RST = 3'h0;
   // error status bit positions
   localparam int ERR_OVR = 0;
   localparam int ERR_FRM = 1;
   localparam int ERR_PAR = 2;
   // event bit positions
   localparam int EV_TX_DONE = 0;
   localparam int EV_RX_DONE = 1;
   localparam int EV_RX_ERR = 2;
   // tx status bit positions
   localparam int TXS_BUSY = 0;
   localparam int TXS_FULL = 1;
   // base clocks an enable must stay off before it may come back
   localparam logic [1:0] OFF_TICKS = 2'd2;

   typedef struct packed {
      logic tx_enable_bit;
      logic rx_enable_bit;
      logic parity_sel_hi;
      logic parity_sel_lo;
      logic char_length_bit;
      logic stop_length_bit;
      logic rx_error_irq_mode;
   } mode_t;

   typedef enum logic [2:0] {
      TX_IDLE = 3'b000,
      TX_START = 3'b001,
      TX_DATA = 3'b010,
      TX_PAR = 3'b011,
      TX_STOP = 3'b100
   } tx_state_t;

   typedef enum logic [2:0] {
      RX_IDLE = 3'b000,
      RX_START = 3'b001,
      RX_DATA = 3'b010,
      RX_PAR = 3'b011,
      RX_STOP = 3'b100
   } rx_state_t;
endpackage

// File: rtl/base_tick_gen.sv
// base clock enable divider
`timescale 1ns/1ps
module base_tick_gen
   import serial_pkg::*;
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic srst_i,
   // divide setting: tick every div_i+1 cycles
   input wire logic [7:0] div_i,
   output logic tick_o
);
   logic [7:0] cnt_r;
   wire wrap = (cnt_r >= div_i);

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         cnt_r <= 8'h00;
         tick_o <= 1'b0;
      end else begin
         cnt_r <= wrap ? 8'h00 : 8'(cnt_r + 8'h01);
         tick_o <= wrap;
      end
   end
endmodule

// File: rtl/async_serial.sv
// asynchronous serial unit: config, status, transmit and receive
// Contract
// [R01] software waits one base clock after tx enable before first buffer write
// [R02] software clears both enables before changing parity or character length
// [R03] software keeps parity selection at none for LIN use
// [R04] software clears tx enable before changing stop length
// [R05] receiver always uses one stop bit, ignoring stop length setting
// [R06] software changes error interrupt mode only with rx enable clear
// [R07] parity error flag follows selected mode: none, zero, odd, even; code checks only odd and even, zero mode never flags
// [R08] framing check looks only at the first stop bit
// [R09] on overrun the new character is discarded, old buffer kept
// [R10] reading reception error status inserts a bus wait cycle
// [R11] software avoids that read while peripheral clock is stopped
// [R12] software checks buffer-full is 0 before writing next byte
// [R13] software waits completion interrupt and shift-busy 0 before reinit
// [R14] enables sync to base clock; re-enable needs two base clocks off
// [R15] buffer-full set on write, cleared on load; busy until last stop
//
// The register offsets and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
module async_serial
   import serial_pkg::*;
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic srst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // serial line
   input wire logic rxd_i,
   output logic txd_o,
   // interrupt
   output logic irq_o
);
   // expected parity bit for a character in the given mode
   function automatic logic par_bit(input logic [7:0] d, input logic cl, input logic [1:0] ps);
      logic p;
      p = ^(cl ? d : {1'b0, d[6:0]});
      case (ps)
         2'b10: par_bit = ~p;
         2'b11: par_bit = p;
         default: par_bit = 1'b0;
      endcase
   endfunction

   mode_t mode_r;
   logic [7:0] base_div_r, bit_len_r, tx_buf_r, rx_buf_r;
   logic [2:0] err_r, ev_r, mask_r;
   logic ack_r, wait_r, tick;
   logic tx_full_r, tx_busy_r, rx_full_r;
   logic tx_done_p, rx_done_p, rx_err_p;
   logic [1:0] en_eff_r;
   logic [1:0] off_cnt_r [2];

   base_tick_gen u_tick (
      .core_clk_i(core_clk_i),
      .srst_i(srst_i),
      .div_i(base_div_r),
      .tick_o(tick)
   );

   // bus decode
   wire req = wb_cyc_i & wb_stb_i & ~ack_r;
   wire err_rd = ~wb_we_i & (wb_adr_i == ERRSTAT_OFS);
   wire go = req & (~err_rd | wait_r); // [R10]
   wire wr = go & wb_we_i & wb_sel_i[0];
   wire rd = go & ~wb_we_i;
   wire [7:0] wd = wb_dat_i[7:0];
   wire wr_mode = wr & (wb_adr_i == MODE_OFS);
   wire wr_txb = wr & (wb_adr_i == TXBUF_OFS);
   wire wr_irq = wr & (wb_adr_i == IRQSTAT_OFS);
   wire rd_err = rd & (wb_adr_i == ERRSTAT_OFS);
   wire rd_rxb = rd & (wb_adr_i == RXBUF_OFS);
   wire [1:0] ps = {mode_r.parity_sel_hi, mode_r.parity_sel_lo};
   wire has_par = (ps != 2'b00);
   wire [2:0] last_idx = mode_r.char_length_bit ? 3'd7 : 3'd6;
   wire [7:0] bit_end = 8'(bit_len_r - 8'h01);
   wire [7:0] half_end = 8'(bit_len_r >> 1);
   wire tx_eff = en_eff_r[1];
   wire rx_eff = en_eff_r[0];
   wire [1:0] en_req = {mode_r.tx_enable_bit, mode_r.rx_enable_bit};
   logic [31:0] rd_mux;
   assign rd_mux =
      (wb_adr_i == MODE_OFS) ? {25'h0, mode_r} :
      (wb_adr_i == ERRSTAT_OFS) ? {29'h0, err_r} :
      (wb_adr_i == TXSTAT_OFS) ? {30'h0, tx_full_r, tx_busy_r} :
      (wb_adr_i == RXBUF_OFS) ? {24'h0, rx_buf_r} :
      (wb_adr_i == BASEDIV_OFS) ? {24'h0, base_div_r} :
      (wb_adr_i == BITLEN_OFS) ? {24'h0, bit_len_r} :
      (wb_adr_i == IRQSTAT_OFS) ? {29'h0, ev_r} :
      (wb_adr_i == IRQMASK_OFS) ? {29'h0, mask_r} : 32'h0;

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         ack_r <= 1'b0;
         wait_r <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         ack_r <= go;
         wait_r <= req & err_rd & ~wait_r;
         wb_dat_o <= rd ? rd_mux : 32'h0;
      end
   end
   assign wb_ack_o = ack_r;

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         mode_r <= MODE_RST;
         base_div_r <= BASEDIV_RST;
         bit_len_r <= BITLEN_RST;
         mask_r <= IRQMASK_RST;
      end else if (wr) begin
         if (wb_adr_i == MODE_OFS) mode_r <= wd[6:0];
         if (wb_adr_i == BASEDIV_OFS) base_div_r <= wd;
         if (wb_adr_i == BITLEN_OFS) bit_len_r <= (wd < 8'h02) ? 8'h02 : wd;
         if (wb_adr_i == IRQMASK_OFS) mask_r <= wd[2:0];
      end
   end

   // enables follow the register only on base ticks, after two ticks off
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         en_eff_r <= 2'b00;
         off_cnt_r[0] <= OFF_TICKS;
         off_cnt_r[1] <= OFF_TICKS;
      end else if (tick) begin
         for (int i = 0; i < 2; i++) begin
            if (!en_req[i]) begin
               en_eff_r[i] <= 1'b0;
               if (en_eff_r[i]) off_cnt_r[i] <= 2'd0;
               else if (off_cnt_r[i] != OFF_TICKS) off_cnt_r[i] <= 2'(off_cnt_r[i] + 2'd1);
            end else if (off_cnt_r[i] == OFF_TICKS) begin
               en_eff_r[i] <= 1'b1; // [R14]
            end
         end
      end
   end

   // interrupt status, write one to clear, set wins
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         ev_r <= 3'h0;
         irq_o <= 1'b0;
      end else begin
         ev_r <= (ev_r & ~(wr_irq ? wd[2:0] : 3'h0)) | {rx_err_p, rx_done_p, tx_done_p};
         irq_o <= |(ev_r & mask_r);
      end
   end

   // transmitter
   tx_state_t tx_st_r;
   logic [7:0] tx_sh_r, tx_cnt_r;
   logic [2:0] tx_idx_r;
   logic tx_stop2_r;
   wire tx_bit_end = tick & (tx_cnt_r == bit_end);

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         tx_st_r <= TX_IDLE;
         tx_sh_r <= 8'h00;
         tx_buf_r <= 8'h00;
         tx_cnt_r <= 8'h00;
         tx_idx_r <= 3'd0;
         tx_stop2_r <= 1'b0;
         tx_full_r <= 1'b0;
         tx_busy_r <= 1'b0;
         tx_done_p <= 1'b0;
         txd_o <= 1'b1;
      end else begin
         tx_done_p <= 1'b0;
         if (wr_txb) begin
            tx_buf_r <= wd;
            tx_full_r <= 1'b1; // [R15]
         end
         if (!tx_eff) begin
            tx_st_r <= TX_IDLE;
            tx_busy_r <= 1'b0;
            txd_o <= 1'b1;
            if (!wr_txb) tx_full_r <= 1'b0;
         end else if (tick) begin
            tx_cnt_r <= tx_bit_end ? 8'h00 : 8'(tx_cnt_r + 8'h01);
            unique case (tx_st_r)
               TX_IDLE: begin
                  tx_cnt_r <= 8'h00;
                  if (tx_full_r) begin
                     tx_sh_r <= tx_buf_r;
                     if (!wr_txb) tx_full_r <= 1'b0; // [R15]
                     tx_busy_r <= 1'b1;
                     tx_idx_r <= 3'd0;
                     txd_o <= 1'b0;
                     tx_st_r <= TX_START;
                  end
               end
               TX_START: if (tx_bit_end) begin
                  txd_o <= tx_sh_r[0];
                  tx_st_r <= TX_DATA;
               end
               TX_DATA: if (tx_bit_end) begin
                  if (tx_idx_r == last_idx) begin
                     txd_o <= has_par ? par_bit(tx_sh_r, mode_r.char_length_bit, ps) : 1'b1;
                     tx_stop2_r <= mode_r.stop_length_bit;
                     tx_st_r <= has_par ? TX_PAR : TX_STOP;
                  end else begin
                     txd_o <= tx_sh_r[tx_idx_r + 3'd1];
                     tx_idx_r <= 3'(tx_idx_r + 3'd1);
                  end
               end
               TX_PAR: if (tx_bit_end) begin
                  txd_o <= 1'b1;
                  tx_st_r <= TX_STOP;
               end
               TX_STOP: if (tx_bit_end) begin
                  if (tx_stop2_r) tx_stop2_r <= 1'b0;
                  else begin
                     tx_busy_r <= 1'b0; // [R15]
                     tx_done_p <= 1'b1;
                     tx_st_r <= TX_IDLE;
                  end
               end
               default: tx_st_r <= TX_IDLE;
            endcase
         end
      end
   end

   // receiver
   logic rxd_meta_r, rxd_s_r;
   rx_state_t rx_st_r;
   logic [7:0] rx_sh_r, rx_cnt_r;
   logic [2:0] rx_idx_r;
   logic rx_perr_r;
   logic [2:0] err_set;
   wire rx_bit_end = tick & (rx_cnt_r == bit_end);

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         rxd_meta_r <= 1'b1;
         rxd_s_r <= 1'b1;
      end else begin
         rxd_meta_r <= rxd_i;
         rxd_s_r <= rxd_meta_r;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         rx_st_r <= RX_IDLE;
         rx_sh_r <= 8'h00;
         rx_buf_r <= 8'h00;
         rx_cnt_r <= 8'h00;
         rx_idx_r <= 3'd0;
         rx_perr_r <= 1'b0;
         rx_full_r <= 1'b0;
         err_set <= 3'h0;
         rx_done_p <= 1'b0;
         rx_err_p <= 1'b0;
      end else begin
         err_set <= 3'h0;
         rx_done_p <= 1'b0;
         rx_err_p <= 1'b0;
         if (rd_rxb) rx_full_r <= 1'b0;
         if (!rx_eff) rx_st_r <= RX_IDLE;
         else if (tick) begin
            rx_cnt_r <= rx_bit_end ? 8'h00 : 8'(rx_cnt_r + 8'h01);
            unique case (rx_st_r)
               RX_IDLE: begin
                  rx_cnt_r <= 8'h00;
                  rx_sh_r <= 8'h00;
                  rx_idx_r <= 3'd0;
                  if (!rxd_s_r) rx_st_r <= RX_START;
               end
               RX_START: if (rx_cnt_r == half_end) begin
                  rx_cnt_r <= 8'h00;
                  rx_st_r <= rxd_s_r ? RX_IDLE : RX_DATA;
               end
               RX_DATA: if (rx_bit_end) begin
                  rx_sh_r[rx_idx_r] <= rxd_s_r;
                  rx_idx_r <= 3'(rx_idx_r + 3'd1);
                  if (rx_idx_r == last_idx) rx_st_r <= has_par ? RX_PAR : RX_STOP;
               end
               RX_PAR: if (rx_bit_end) begin
                  rx_perr_r <= ps[1] & (rxd_s_r != par_bit(rx_sh_r, mode_r.char_length_bit, ps)); // [R07]
                  rx_st_r <= RX_STOP;
               end
               RX_STOP: if (rx_bit_end) begin
                  // only one stop bit is sampled, then back to hunting
                  rx_st_r <= RX_IDLE; // [R05]
                  err_set[ERR_FRM] <= ~rxd_s_r; // [R08]
                  err_set[ERR_PAR] <= has_par & rx_perr_r;
                  err_set[ERR_OVR] <= rx_full_r & ~rd_rxb;
                  if (!(rx_full_r & ~rd_rxb)) begin
                     rx_buf_r <= rx_sh_r; // [R09]
                     rx_full_r <= 1'b1;
                  end
                  if (~rxd_s_r | (has_par & rx_perr_r) | (rx_full_r & ~rd_rxb)) begin
                     rx_done_p <= mode_r.rx_error_irq_mode;
                     rx_err_p <= ~mode_r.rx_error_irq_mode;
                  end else begin
                     rx_done_p <= 1'b1;
                  end
                  rx_perr_r <= 1'b0;
               end
               default: rx_st_r <= RX_IDLE;
            endcase
         end
      end
   end

   // error status: cleared by reading it, a new error wins
   always_ff @(posedge core_clk_i) begin
      if (srst_i) err_r <= 3'h0;
      else err_r <= (rd_err ? 3'h0 : err_r) | err_set;
   end
endmodule

// File: tb/async_serial_properties.sv
// assertion checker for the asynchronous serial unit
`timescale 1ns/1ps
module async_serial_properties
   import serial_pkg::*;
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic srst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // serial line and interrupt
   input wire logic rxd_i,
   input wire logic txd_o,
   input wire logic irq_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (srst_i);

   a_errstat_wait: assert property ($rose(wb_stb_i) && !wb_we_i && wb_adr_i == ERRSTAT_OFS
      |=> !wb_ack_o ##1 wb_ack_o) else $error("error status read not one wait");
   a_ack_prompt: assert property ($rose(wb_stb_i) && !(!wb_we_i && wb_adr_i == ERRSTAT_OFS)
      |=> wb_ack_o) else $error("ack late");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than a cycle");
   a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data outside ack");
   a_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
      else $error("upper read bits set");
   a_irq_masked: assert property (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == IRQMASK_OFS
      && wb_dat_i[2:0] == 3'h0 |=> ##1 !irq_o) else $error("irq with mask clear");
   // bench runs four or more core cycles per bit
   a_tx_bit_hold: assert property ($changed(txd_o) |=> $stable(txd_o)[*3])
      else $error("tx bit too short");
   a_reset_quiet: assert property ($past(srst_i) |-> txd_o && !irq_o && !wb_ack_o)
      else $error("outputs not idle after reset");

   c_irq_rise: cover property ($rose(irq_o));
   c_tx_start: cover property ($fell(txd_o));
   c_par_err: cover property (wb_ack_o && wb_adr_i == ERRSTAT_OFS && wb_dat_o[ERR_PAR]);
endmodule

bind async_serial async_serial_properties async_serial_properties_inst (
   .core_clk_i(core_clk_i), .srst_i(srst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rxd_i(rxd_i), .txd_o(txd_o), .irq_o(irq_o));

// File: tb/serial_peer.sv
// remote serial node: frame sender and byte catcher
`timescale 1ns/1ps
module serial_peer #(
   parameter int BIT_CYC = 4
)
(
   // clock
   input wire logic core_clk_i,
   // serial lines seen from the node
   input wire logic line_in_i,
   output logic line_out_o
);
   logic [7:0] last_byte_r;
   logic [7:0] prev_byte_r;

   initial begin
      line_out_o = 1'b1;
      last_byte_r = 8'h00;
      prev_byte_r = 8'h00;
   end

   // lsb first, line back to idle high after the frame
   task automatic send_bits(input logic [11:0] bits, input int n);
      for (int i = 0; i < n; i++) begin
         line_out_o <= bits[i];
         repeat (BIT_CYC) @(posedge core_clk_i);
      end
      line_out_o <= 1'b1;
   endtask

   // catch 8-bit frames, sampled near mid bit
   always begin
      @(posedge core_clk_i);
      if (line_in_i === 1'b0) begin
         prev_byte_r = last_byte_r;
         repeat (BIT_CYC + BIT_CYC / 2) @(posedge core_clk_i);
         for (int i = 0; i < 8; i++) begin
            last_byte_r = {line_in_i, last_byte_r[7:1]};
            repeat (BIT_CYC) @(posedge core_clk_i);
         end
      end
   end
endmodule

// File: tb/async_serial_tb_top.sv
// self-checking bench for the asynchronous serial unit
`timescale 1ns/1ps
module async_serial_tb_top;
   import serial_pkg::*;
   logic core_clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hf;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic rxd_i;
   logic txd_o;
   logic irq_o;
   logic [31:0] rd;
   int mismatches = 0;
   int n_checks = 0;

   initial begin
      forever #25 core_clk_i = ~core_clk_i;
   end

   async_serial async_serial_inst (.core_clk_i(core_clk_i), .srst_i(srst_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .rxd_i(rxd_i), .txd_o(txd_o), .irq_o(irq_o));
   serial_peer #(.BIT_CYC(4)) serial_peer_inst (.core_clk_i(core_clk_i), .line_in_i(txd_o),
      .line_out_o(rxd_i));

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   // one classic cycle, held until ack is sampled
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                     output logic [31:0] q);
      int n;
      @(posedge core_clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      n = 0;
      do begin
         @(posedge core_clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (wb_ack_o !== 1'b1) begin
         mismatches++;
         print_verdict();
      end
   endtask

   task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
      wb(1'b1, adr, dat, rd);
   endtask

   task automatic rc(input string name, input logic [7:0] adr, input logic [31:0] exp);
      wb(1'b0, adr, 32'h0, rd);
      chk(name, exp, rd);
   endtask

   // read until any masked bit is set, or all are clear, as asked
   task automatic poll(input logic [7:0] adr, input logic [31:0] mask, input logic set);
      int n;
      n = 0;
      do begin
         wb(1'b0, adr, 32'h0, rd);
         n++;
      end while (((rd & mask) != 32'h0) !== set && n < 300);
      if (((rd & mask) != 32'h0) !== set) begin
         mismatches++;
         print_verdict();
      end
   endtask

   // parity bit, when present, is always one
   task automatic frame(input logic [7:0] d, input logic pe, input logic stp);
      if (pe) begin
         serial_peer_inst.send_bits({1'b1, stp, 1'b1, d, 1'b0}, 11);
      end else begin
         serial_peer_inst.send_bits({2'b11, stp, d, 1'b0}, 10);
      end
   endtask

   initial begin
      repeat (6) @(posedge core_clk_i);
      srst_i <= 1'b0;
      rc("mode", MODE_OFS, 32'h0);
      rc("bitlen", BITLEN_OFS, 32'h10);
      rc("mask", IRQMASK_OFS, 32'h0);
      rc("txstat", TXSTAT_OFS, 32'h0);
      rc("unmapped", 8'h30, 32'h0);
      // write with byte lane 0 off must store nothing
      wb_sel_i <= 4'he;
      wr(BASEDIV_OFS, 32'h55);
      wb_sel_i <= 4'hf;
      rc("sel0 ignored", BASEDIV_OFS, 32'h0);
      wr(BITLEN_OFS, 32'h1);
      rc("bitlen floor", BITLEN_OFS, 32'h2);
      wr(BITLEN_OFS, 32'h4);
      wr(BASEDIV_OFS, 32'h0);
      wr(MODE_OFS, 32'h04);
      wr(MODE_OFS, 32'h64);
      wr(TXBUF_OFS, 32'ha5);
      poll(TXSTAT_OFS, 32'h2, 1'b0);
      wr(TXBUF_OFS, 32'h5a);
      poll(IRQSTAT_OFS, 32'h1, 1'b1);
      poll(TXSTAT_OFS, 32'h3, 1'b0);
      chk("tx first", 32'ha5, {24'h0, serial_peer_inst.prev_byte_r});
      chk("tx second", 32'h5a, {24'h0, serial_peer_inst.last_byte_r});
      wr(IRQMASK_OFS, 32'h1);
      repeat (2) @(posedge core_clk_i);
      chk("irq on", 32'h1, {31'h0, irq_o});
      wr(IRQMASK_OFS, 32'h0);
      repeat (2) @(posedge core_clk_i);
      chk("irq off", 32'h0, {31'h0, irq_o});
      wr(IRQSTAT_OFS, 32'h7);
      rc("irqstat", IRQSTAT_OFS, 32'h0);
      frame(8'h11, 1'b0, 1'b1);
      poll(IRQSTAT_OFS, 32'h2, 1'b1);
      wr(IRQSTAT_OFS, 32'h7);
      frame(8'h22, 1'b0, 1'b1);
      poll(IRQSTAT_OFS, 32'h4, 1'b1);
      rc("overrun", ERRSTAT_OFS, 32'h1);
      rc("rx kept", RXBUF_OFS, 32'h11);
      for (int m = 0; m < 4; m++) begin
         wr(MODE_OFS, 32'h04 | (32'(m) << 3));
         wr(MODE_OFS, 32'h64 | (32'(m) << 3));
         wr(IRQSTAT_OFS, 32'h7);
         frame(8'h07, m != 0, 1'b1);
         poll(IRQSTAT_OFS, 32'h6, 1'b1);
         rc("parity", ERRSTAT_OFS, (m == 2) ? 32'h4 : 32'h0);
         rc("rx parity", RXBUF_OFS, 32'h07);
      end
      wr(MODE_OFS, 32'h07);
      wr(MODE_OFS, 32'h67);
      wr(IRQSTAT_OFS, 32'h7);
      frame(8'h33, 1'b0, 1'b1);
      poll(IRQSTAT_OFS, 32'h6, 1'b1);
      rc("one stop", ERRSTAT_OFS, 32'h0);
      rc("rx one stop", RXBUF_OFS, 32'h33);
      wr(IRQSTAT_OFS, 32'h7);
      frame(8'h44, 1'b0, 1'b0);
      poll(IRQSTAT_OFS, 32'h6, 1'b1);
      rc("irq mode", IRQSTAT_OFS, 32'h2);
      rc("framing", ERRSTAT_OFS, 32'h2);
      rc("rx framed", RXBUF_OFS, 32'h44);
      // seven data bits, two stop bits on transmit
      wr(MODE_OFS, 32'h02);
      wr(MODE_OFS, 32'h62);
      wr(TXBUF_OFS, 32'h55);
      poll(TXSTAT_OFS, 32'h3, 1'b0);
      chk("tx 7 bit", 32'hd5, {24'h0, serial_peer_inst.last_byte_r});
      wr(IRQSTAT_OFS, 32'h7);
      serial_peer_inst.send_bits({4'hf, 7'h2a, 1'b0}, 9);
      poll(IRQSTAT_OFS, 32'h6, 1'b1);
      rc("rx 7 bit err", ERRSTAT_OFS, 32'h0);
      rc("rx 7 bit", RXBUF_OFS, 32'h2a);
      print_verdict();
   end
endmodule
